// ===== logic/arcp_consts.vh
// constants of the remote command parser
// Overview of operation
// - lines are 7-bit ascii ended by line feed
// - no line length limit, only terminator ends
// - remote command enters and holds remote control
// - local command or control key returns local
// - power-on always starts in local control
// - mode change refused while amplifier operates
// - operate and standby commands, state query
// - standby state answers with the standby string
// - control query names local, gpib, lan, ttl
// - fault query gives all-clear or fault name
// - over-temperature reply carries the sensor number
// - identification reply: maker, model, serial
// - reply sent only when loaded and talker-addressed
// - another command line discards the pending reply
// - every reply ends with a line feed
// - fault raises a service request unprompted
// - serial poll answered with fault status byte
// - latched fault cleared only by reset command
// - device clear aborts line, keeps settings
`ifndef ARCP_CONSTS_VH
`define ARCP_CONSTS_VH
`define ARCP_LF 8'h0A
`define ARCP_ZERO 8'h30
`define ARCP_LEN_SAT 4'h9
`define ARCP_FIFO_W 8
`define ARCP_FIFO_D 4
`define ARCP_FIFO_AW 2
// command texts, right aligned, with their lengths
`define ARCP_C_REMOTE 64'h0000_5245_4D4F_5445
`define ARCP_C_LOCAL 64'h0000_004C_4F43_414C
`define ARCP_C_OPER 64'h0000_414D_505F_4F4E
`define ARCP_C_STBY 64'h0041_4D50_5F4F_4646
`define ARCP_C_PWRQ 64'h0000_0000_414D_503F
`define ARCP_C_IDNQ 64'h0000_002A_4944_4E3F
`define ARCP_C_RST 64'h0000_0000_2A52_5354
`define ARCP_C_CTLQ 64'h434F_4E54_524F_4C3F
`define ARCP_C_STSQ 64'h0053_5441_5455_533F
`define ARCP_L4 4'h4
`define ARCP_L5 4'h5
`define ARCP_L6 4'h6
`define ARCP_L7 4'h7
`define ARCP_L8 4'h8
// reply texts
`define ARCP_S_OPER 48'h414D_505F_4F4E
`define ARCP_S_STBY 56'h41_4D50_5F4F_4646
`define ARCP_S_LOCAL 40'h4C_4F43_414C
`define ARCP_S_GPIB 32'h4750_4942
`define ARCP_S_LAN 24'h4C_414E
`define ARCP_S_TTL 24'h54_544C
`define ARCP_S_OK 72'h53_5953_5445_4D5F_4F4B
`define ARCP_S_ILK 144'h496E_7465_726C_6F63_6B20_4578_7465_726E_616C
`define ARCP_S_TEMP 96'h5465_6D70_6572_6174_7572_6520
`define ARCP_S_PSU 96'h506F_7765_7253_7570_706C_7920
`define ARCP_S_CTLF 104'h43_6F6E_7472_6F6C_2046_6175_6C74
`define ARCP_ID_BITS 128
`define ARCP_ID_LEN 5'h10
// reply selectors
`define ARCP_R_NONE 4'h0
`define ARCP_R_ID 4'h1
`define ARCP_R_OPER 4'h2
`define ARCP_R_STBY 4'h3
`define ARCP_R_LOCAL 4'h4
`define ARCP_R_GPIB 4'h5
`define ARCP_R_LAN 4'h6
`define ARCP_R_TTL 4'h7
`define ARCP_R_OK 4'h8
`define ARCP_R_ILK 4'h9
`define ARCP_R_TEMP 4'hA
`define ARCP_R_PSU 4'hB
`define ARCP_R_CTLF 4'hC
// control points
`define ARCP_CP_LOCAL 2'h0
`define ARCP_CP_GPIB 2'h1
`define ARCP_CP_LAN 2'h2
`define ARCP_CP_TTL 2'h3
// latched fault codes
`define ARCP_F_NONE 3'h0
`define ARCP_F_ILK 3'h1
`define ARCP_F_TEMP 3'h2
`define ARCP_F_PSU 3'h3
`define ARCP_F_CTL 3'h4
`define ARCP_STB_RQS 6
`endif

// ===== logic/arcp_parser.v
// command fifo and remote command parser of the amplifier
`timescale 1ns/100ps
`default_nettype none
`include "arcp_consts.vh"

module arcp_fifo #(
   parameter W = 8,
   parameter D = 4,
   parameter AW = 2
) (
   input wire mclk,
   input wire srst,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1]; // storage words
   reg [AW:0] wp_ff; // write pointer, extra wrap bit
   reg [AW:0] rp_ff; // read pointer, extra wrap bit
   wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   wire empty = (wp_ff == rp_ff);
   wire do_wr = in_valid && !full;
   wire do_rd = out_valid && out_ready;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_ff[AW-1:0]];

   // storage has no reset, only pointers need one
   always @(posedge mclk)
   begin
      if (do_wr)
         mem[wp_ff[AW-1:0]] <= in_data;
   end

   // pointers; flush drops everything queued
   always @(posedge mclk)
   begin
      if (srst || flush)
      begin
         wp_ff <= {(AW+1){1'b0}};
         rp_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wp_ff <= wp_ff + 1'b1;
         if (do_rd)
            rp_ff <= rp_ff + 1'b1;
      end
   end
endmodule

module arcp_parser #(
   // identification reply, value arbitrary
   parameter [`ARCP_ID_BITS-1:0] ID_TEXT = 128'h4D46_522C_2041_4D50_3031_2C20_3030_3030
) (
   input wire mclk,
   input wire srst,
   input wire rx_valid,
   output wire rx_ready,
   input wire [7:0] rx_data,
   input wire rx_is_gpib,
   input wire dev_clear,
   input wire talk_en,
   output wire tx_valid,
   input wire tx_ready,
   output wire [7:0] tx_data,
   input wire key_local,
   input wire ttl_req,
   input wire fault_ilk,
   input wire fault_temp,
   input wire [3:0] temp_num,
   input wire fault_psu,
   input wire [3:0] psu_num,
   input wire fault_ctl,
   input wire spoll_req,
   output wire [7:0] stb_data,
   output wire stb_valid,
   output wire srq,
   output wire amp_operate,
   output wire [1:0] ctrl_point,
   output wire fault_active,
   output wire cmd_refused
);
   reg [63:0] sh_ff; // characters of the current line
   reg [3:0] len_ff; // saturating character count
   reg bad_ff; // non 7-bit character seen
   reg [3:0] rsel_ff; // pending reply selector
   reg [3:0] rnum_ff; // digit for numbered replies
   reg [4:0] ridx_ff; // next reply character
   reg [7:0] txd_ff; // outgoing character
   reg txv_ff; // outgoing character valid
   reg [1:0] cp_ff; // control point
   reg op_ff; // operate when set
   reg [2:0] flt_ff; // latched fault
   reg [3:0] fnum_ff; // latched fault number
   reg srq_ff; // service request
   reg [7:0] stb_ff; // serial poll byte
   reg stbv_ff; // serial poll byte valid
   reg ref_ff; // refused pulse
   wire f_valid; // fifo has a character
   wire [7:0] f_data; // fifo head
   wire p_ready; // parser takes a character
   wire take = f_valid && p_ready;
   wire eol = take && (f_data == `ARCP_LF);
   wire [8:0] rchr; // {last, character} of reply
   wire load = (rsel_ff != `ARCP_R_NONE) && talk_en && (!txv_ff || tx_ready);

   // queue stalls the sender while a reply goes out
   arcp_fifo #(
      .W(`ARCP_FIFO_W),
      .D(`ARCP_FIFO_D),
      .AW(`ARCP_FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .flush(dev_clear),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(f_valid),
      .out_ready(p_ready),
      .out_data(f_data)
   );

   // hold input while talking, or the line would discard the reply
   assign p_ready = !(talk_en && (rsel_ff != `ARCP_R_NONE)) && !dev_clear;

   // reply text lookup; index equal to length gives line feed
   function [8:0] arcp_chr;
      input [3:0] sel;
      input [4:0] idx;
      input [3:0] num;
      reg [143:0] s;
      reg [4:0] n;
      reg [7:0] amt;
      reg [143:0] t;
      begin
         s = 144'h0;
         n = 5'h0;
         case (sel)
            `ARCP_R_ID: begin s = {16'h0, ID_TEXT}; n = `ARCP_ID_LEN; end
            `ARCP_R_OPER: begin s = {96'h0, `ARCP_S_OPER}; n = 5'h06; end
            `ARCP_R_STBY: begin s = {88'h0, `ARCP_S_STBY}; n = 5'h07; end
            `ARCP_R_LOCAL: begin s = {104'h0, `ARCP_S_LOCAL}; n = 5'h05; end
            `ARCP_R_GPIB: begin s = {112'h0, `ARCP_S_GPIB}; n = 5'h04; end
            `ARCP_R_LAN: begin s = {120'h0, `ARCP_S_LAN}; n = 5'h03; end
            `ARCP_R_TTL: begin s = {120'h0, `ARCP_S_TTL}; n = 5'h03; end
            `ARCP_R_OK: begin s = {72'h0, `ARCP_S_OK}; n = 5'h09; end
            `ARCP_R_ILK: begin s = `ARCP_S_ILK; n = 5'h12; end
            // numbered faults append one digit
            `ARCP_R_TEMP: begin s = {40'h0, `ARCP_S_TEMP, `ARCP_ZERO + {4'h0, num}}; n = 5'h0D; end
            `ARCP_R_PSU: begin s = {40'h0, `ARCP_S_PSU, `ARCP_ZERO + {4'h0, num}}; n = 5'h0D; end
            `ARCP_R_CTLF: begin s = {40'h0, `ARCP_S_CTLF}; n = 5'h0D; end
            default: begin s = 144'h0; n = 5'h0; end
         endcase
         amt = {n - idx - 5'h1, 3'b000};
         t = s >> amt;
         if (idx >= n)
            arcp_chr = {1'b1, `ARCP_LF};
         else
            arcp_chr = {1'b0, t[7:0]};
      end
   endfunction

   assign rchr = arcp_chr(rsel_ff, ridx_ff, rnum_ff);

   // line assembly; only line feed ends a line
   always @(posedge mclk)
   begin
      if (srst || dev_clear)
      begin
         sh_ff <= 64'h0;
         len_ff <= 4'h0;
         bad_ff <= 1'b0;
      end
      else if (eol)
      begin
         sh_ff <= 64'h0;
         len_ff <= 4'h0;
         bad_ff <= 1'b0;
      end
      else if (take)
      begin
         sh_ff <= {sh_ff[55:0], f_data};
         if (len_ff != `ARCP_LEN_SAT)
            len_ff <= len_ff + 4'h1;
         if (f_data[7])
            bad_ff <= 1'b1;
      end
   end

   // matches, valid only when the line is clean
   wire ok = !bad_ff;
   wire m_rem = ok && len_ff == `ARCP_L6 && sh_ff == `ARCP_C_REMOTE;
   wire m_loc = ok && len_ff == `ARCP_L5 && sh_ff == `ARCP_C_LOCAL;
   wire m_op = ok && len_ff == `ARCP_L6 && sh_ff == `ARCP_C_OPER;
   wire m_sb = ok && len_ff == `ARCP_L7 && sh_ff == `ARCP_C_STBY;
   wire m_pq = ok && len_ff == `ARCP_L4 && sh_ff == `ARCP_C_PWRQ;
   wire m_id = ok && len_ff == `ARCP_L5 && sh_ff == `ARCP_C_IDNQ;
   wire m_rst = ok && len_ff == `ARCP_L4 && sh_ff == `ARCP_C_RST;
   wire m_cq = ok && len_ff == `ARCP_L8 && sh_ff == `ARCP_C_CTLQ;
   wire m_sq = ok && len_ff == `ARCP_L7 && sh_ff == `ARCP_C_STSQ;
   wire mode_req = (eol && (m_rem || m_loc)) || key_local || ttl_req;

   // control point and power state; power-on is local standby
   always @(posedge mclk)
   begin
      if (srst)
      begin
         cp_ff <= `ARCP_CP_LOCAL;
         op_ff <= 1'b0;
         ref_ff <= 1'b0;
      end
      else
      begin
         ref_ff <= mode_req && op_ff;
         if (mode_req && !op_ff)
         begin
            if (eol && m_rem)
               cp_ff <= rx_is_gpib ? `ARCP_CP_GPIB : `ARCP_CP_LAN;
            else if ((eol && m_loc) || key_local)
               cp_ff <= `ARCP_CP_LOCAL;
            else if (ttl_req)
               cp_ff <= (cp_ff == `ARCP_CP_TTL) ? `ARCP_CP_LOCAL : `ARCP_CP_TTL;
         end
         // link commands steer power only under remote control
         if (eol && !key_local && !ttl_req && (cp_ff == `ARCP_CP_GPIB || cp_ff == `ARCP_CP_LAN))
         begin
            if (m_op)
               op_ff <= 1'b1;
            else if (m_sb)
               op_ff <= 1'b0;
         end
      end
   end

   // reply buffer and output character stage
   always @(posedge mclk)
   begin
      if (srst || dev_clear)
      begin
         rsel_ff <= `ARCP_R_NONE;
         rnum_ff <= 4'h0;
         ridx_ff <= 5'h0;
         txd_ff <= 8'h00;
         txv_ff <= 1'b0;
      end
      else
      begin
         if (txv_ff && tx_ready)
            txv_ff <= 1'b0;
         if (eol)
         begin
            // any new line replaces the pending reply
            ridx_ff <= 5'h0;
            rnum_ff <= fnum_ff;
            if (m_id)
               rsel_ff <= `ARCP_R_ID;
            else if (m_pq)
               rsel_ff <= op_ff ? `ARCP_R_OPER : `ARCP_R_STBY;
            else if (m_cq)
               rsel_ff <= {2'b01, cp_ff};
            else if (m_sq)
               rsel_ff <= (flt_ff == `ARCP_F_NONE) ? `ARCP_R_OK : `ARCP_R_OK + {1'b0, flt_ff};
            else
               rsel_ff <= `ARCP_R_NONE;
         end
         else if (load)
         begin
            txd_ff <= rchr[7:0];
            txv_ff <= 1'b1;
            ridx_ff <= ridx_ff + 5'h1;
            if (rchr[8])
               rsel_ff <= `ARCP_R_NONE;
         end
      end
   end

   // fault latch; first fault held until reset command
   wire any_f = fault_ilk || fault_temp || fault_psu || fault_ctl;
   wire [2:0] new_f = fault_ilk ? `ARCP_F_ILK : fault_temp ? `ARCP_F_TEMP :
                      fault_psu ? `ARCP_F_PSU : `ARCP_F_CTL;
   wire [3:0] new_n = fault_temp && !fault_ilk ? temp_num : psu_num;
   wire clr_f = eol && m_rst;
   wire set_f = any_f && (flt_ff == `ARCP_F_NONE || clr_f);

   always @(posedge mclk)
   begin
      if (srst)
      begin
         flt_ff <= `ARCP_F_NONE;
         fnum_ff <= 4'h0;
         srq_ff <= 1'b0;
         stb_ff <= 8'h00;
         stbv_ff <= 1'b0;
      end
      else
      begin
         stbv_ff <= spoll_req;
         // a fault in the clearing cycle stays latched
         if (set_f)
         begin
            flt_ff <= new_f;
            fnum_ff <= new_n;
         end
         else if (clr_f)
         begin
            flt_ff <= `ARCP_F_NONE;
            fnum_ff <= 4'h0;
         end
         // request raised by a new fault, dropped by poll
         if (set_f && new_f != flt_ff)
            srq_ff <= 1'b1;
         else if (spoll_req)
            srq_ff <= 1'b0;
         if (spoll_req)
         begin
            stb_ff <= {5'h0, flt_ff};
            stb_ff[`ARCP_STB_RQS] <= srq_ff;
         end
      end
   end

   assign tx_valid = txv_ff;
   assign tx_data = txd_ff;
   assign stb_data = stb_ff;
   assign stb_valid = stbv_ff;
   assign srq = srq_ff;
   assign amp_operate = op_ff;
   assign ctrl_point = cp_ff;
   assign fault_active = (flt_ff != `ARCP_F_NONE);
   assign cmd_refused = ref_ff;
endmodule
`default_nettype wire

// ===== test/arcp_parser_asserts.sv
// port assertions of the remote command parser
`timescale 1ns/100ps
`default_nettype none
`include "arcp_consts.vh"
module arcp_parser_asserts (
   input wire logic mclk,
   input wire logic srst,
   input wire logic talk_en,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic dev_clear,
   input wire logic key_local,
   input wire logic ttl_req,
   input wire logic fault_ilk,
   input wire logic fault_temp,
   input wire logic fault_psu,
   input wire logic fault_ctl,
   input wire logic spoll_req,
   input wire logic [7:0] stb_data,
   input wire logic stb_valid,
   input wire logic srq,
   input wire logic amp_operate,
   input wire logic [1:0] ctrl_point,
   input wire logic fault_active,
   input wire logic cmd_refused
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // a fresh fault must flag itself without any poll
   AST_SRQ_ON_FAULT: assert property (
      !fault_active && !spoll_req && (fault_ilk || fault_temp || fault_psu || fault_ctl)
      |=> srq && fault_active) else $error("fault raised no service request");
   AST_SRQ_FAULT: assert property (srq |-> fault_active)
      else $error("service request without fault");
   // status byte carries the request bit and the fault code
   AST_STB_POLL: assert property (
      spoll_req |=> stb_valid && stb_data[6] == $past(srq)
      && ((stb_data[2:0] != 3'h0) == $past(fault_active)))
      else $error("status byte wrong after poll");
   AST_SRQ_CLEAR: assert property (spoll_req |=> !srq)
      else $error("service request kept after poll");
   AST_TX_HOLD: assert property (
      tx_valid && !tx_ready && !dev_clear |=> tx_valid && $stable(tx_data))
      else $error("reply character dropped before accept");
   AST_NO_TALK: assert property (!talk_en && !tx_valid |=> !tx_valid)
      else $error("reply sent while not talker");
   AST_REFUSE: assert property (
      amp_operate && (key_local || ttl_req) |-> ##[1:2] cmd_refused)
      else $error("mode change in operate not refused");
   AST_MODE_HOLD: assert property (
      amp_operate && $past(amp_operate) |-> $stable(ctrl_point))
      else $error("control point moved while operating");
   AST_OPER_REMOTE: assert property (
      $rose(amp_operate) |-> ctrl_point == `ARCP_CP_GPIB || ctrl_point == `ARCP_CP_LAN)
      else $error("operate entered without remote control");
   AST_KEY_LOCAL: assert property (
      !amp_operate && key_local && !ttl_req |-> ##[1:2] ctrl_point == `ARCP_CP_LOCAL)
      else $error("control key did not return local");
   // main scenarios reached
   cover property (spoll_req ##1 stb_valid);
   cover property (cmd_refused);
   cover property (tx_valid && tx_ready && tx_data == `ARCP_LF);
endmodule
bind arcp_parser arcp_parser_asserts u_chk (.mclk(mclk), .srst(srst), .talk_en(talk_en),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .dev_clear(dev_clear),
   .key_local(key_local), .ttl_req(ttl_req), .fault_ilk(fault_ilk), .fault_temp(fault_temp),
   .fault_psu(fault_psu), .fault_ctl(fault_ctl), .spoll_req(spoll_req), .stb_data(stb_data),
   .stb_valid(stb_valid), .srq(srq), .amp_operate(amp_operate), .ctrl_point(ctrl_point),
   .fault_active(fault_active), .cmd_refused(cmd_refused));
`default_nettype wire

// ===== test/arcp_ctrl_model.sv
// remote controller model: sends command lines, reads replies
`timescale 1ns/100ps
`default_nettype none
module arcp_ctrl_model (
   input wire logic mclk,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic talk_en,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data
);
   logic [159:0] rbuf; // reply bytes, newest lowest
   integer rlen; // reply length in bytes
   integer tmo; // exhausted waits
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      talk_en = 1'b0;
      tx_ready = 1'b0;
      tmo = 0;
   end
   // hold one byte until the fifo takes it
   task send_byte(input logic [7:0] b);
      integer n;
      logic ok;
      begin
         rx_valid <= 1'b1;
         rx_data <= b;
         ok = 1'b0;
         n = 0;
         while (!ok && n < 50)
         begin
            @(negedge mclk);
            ok = rx_ready;
            @(posedge mclk);
            n = n + 1;
         end
         if (!ok)
            tmo = tmo + 1;
      end
   endtask
   // last len chars of t, 7-bit text, then line feed when lf is set
   task send_line(input logic [63:0] t, input integer len, input logic lf);
      integer i;
      begin
         @(posedge mclk); // idle edge stands in for the lan spacing
         for (i = len - 1; i >= 0; i = i - 1)
            send_byte(t[8*i+:8]);
         if (lf)
            send_byte(8'h0A);
         rx_valid <= 1'b0;
         rx_data <= ~rx_data; // released bus shows no stale byte
      end
   endtask
   // become talker right after the query, optionally stalling
   task read_reply(input logic slow, input integer maxc);
      integer n;
      logic [7:0] c;
      begin
         rbuf = 160'h0;
         rlen = 0;
         c = 8'h00;
         @(posedge mclk);
         talk_en <= 1'b1;
         n = 0;
         while (c !== 8'h0A && n < maxc)
         begin
            tx_ready <= slow ? n[0] : 1'b1;
            @(negedge mclk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1)
            begin
               c = tx_data;
               rbuf = {rbuf[151:0], c};
               rlen = rlen + 1;
            end
            @(posedge mclk);
            n = n + 1;
         end
         talk_en <= 1'b0;
         tx_ready <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ===== test/amp_remote_command_parser_tb_top.sv
// self-checking bench of the remote command parser
`timescale 1ns/100ps
`default_nettype none
`include "arcp_consts.vh"
module amp_remote_command_parser_tb_top;
   // identification text, value arbitrary
   localparam [127:0] ID = 128'h5859_5A2C_2055_4E49_5439_2C20_3030_3031;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic rx_is_gpib = 1'b0, dev_clear = 1'b0, key_local = 1'b0, ttl_req = 1'b0;
   logic fault_ilk = 1'b0, fault_temp = 1'b0, fault_psu = 1'b0, fault_ctl = 1'b0;
   logic spoll_req = 1'b0;
   logic [3:0] temp_num = 4'h0, psu_num = 4'h0;
   wire logic rx_valid, rx_ready, talk_en, tx_valid, tx_ready, stb_valid, srq;
   wire logic amp_operate, fault_active, cmd_refused;
   wire logic [7:0] rx_data, tx_data, stb_data;
   wire logic [1:0] ctrl_point;
   integer num_errors = 0;
   integer compares = 0;
   always #5 mclk = ~mclk;
   arcp_parser #(.ID_TEXT(ID)) u_dut (.mclk(mclk), .srst(srst), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .rx_is_gpib(rx_is_gpib), .dev_clear(dev_clear),
      .talk_en(talk_en), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .key_local(key_local), .ttl_req(ttl_req), .fault_ilk(fault_ilk), .fault_temp(fault_temp),
      .temp_num(temp_num), .fault_psu(fault_psu), .psu_num(psu_num), .fault_ctl(fault_ctl),
      .spoll_req(spoll_req), .stb_data(stb_data), .stb_valid(stb_valid), .srq(srq),
      .amp_operate(amp_operate), .ctrl_point(ctrl_point), .fault_active(fault_active),
      .cmd_refused(cmd_refused));
   arcp_ctrl_model u_ctl (.mclk(mclk), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .talk_en(talk_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data));
   task chk_val(input logic [7:0] got, input logic [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t output %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_reply(input logic [159:0] exp, input integer n);
      begin
         compares = compares + 1;
         if (u_ctl.rlen != n || u_ctl.rbuf !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t reply %h expected %h", $time, u_ctl.rbuf, exp);
         end
      end
   endtask
   // settle on a falling edge so checks never race the design
   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk);
         @(negedge mclk);
      end
   endtask
   task cmd(input logic [63:0] t, input integer len);
      begin
         u_ctl.send_line(t, len, 1'b1);
         tick(4);
      end
   endtask
   task qry(input logic [63:0] t, input integer len, input logic slow);
      begin
         u_ctl.send_line(t, len, 1'b1);
         u_ctl.read_reply(slow, 80);
      end
   endtask
   task close_out;
      begin
         num_errors = num_errors + u_ctl.tmo;
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // hang guard
   initial
   begin
      #200000;
      num_errors = num_errors + 1;
      close_out;
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      tick(1);
      chk_val({6'h00, ctrl_point}, 8'h00);
      cmd(`ARCP_C_OPER, 6);
      chk_val({7'h00, amp_operate}, 8'h00);
      cmd(`ARCP_C_REMOTE, 6);
      chk_val({6'h00, ctrl_point}, {6'h00, `ARCP_CP_LAN});
      qry(`ARCP_C_PWRQ, 4, 1'b1);
      chk_reply({`ARCP_S_STBY, 8'h0A}, 8);
      cmd(`ARCP_C_OPER, 6);
      chk_val({7'h00, amp_operate}, 8'h01);
      cmd(`ARCP_C_LOCAL, 5);
      @(posedge mclk);
      key_local <= 1'b1;
      @(posedge mclk);
      key_local <= 1'b0;
      @(negedge mclk);
      chk_val({7'h00, cmd_refused}, 8'h01);
      tick(3);
      chk_val({6'h00, ctrl_point}, {6'h00, `ARCP_CP_LAN});
      qry(`ARCP_C_PWRQ, 4, 1'b0);
      chk_reply({`ARCP_S_OPER, 8'h0A}, 7);
      qry(`ARCP_C_CTLQ, 8, 1'b0);
      chk_reply({`ARCP_S_LAN, 8'h0A}, 4);
      cmd(`ARCP_C_STBY, 7);
      cmd(`ARCP_C_LOCAL, 5);
      chk_val({6'h00, ctrl_point}, {6'h00, `ARCP_CP_LOCAL});
      @(posedge mclk);
      rx_is_gpib <= 1'b1;
      cmd(`ARCP_C_REMOTE, 6);
      qry(`ARCP_C_CTLQ, 8, 1'b0);
      chk_reply({`ARCP_S_GPIB, 8'h0A}, 5);
      @(posedge mclk);
      key_local <= 1'b1;
      @(posedge mclk);
      key_local <= 1'b0;
      ttl_req <= 1'b1;
      @(posedge mclk);
      ttl_req <= 1'b0;
      qry(`ARCP_C_CTLQ, 8, 1'b0);
      chk_reply({`ARCP_S_TTL, 8'h0A}, 4);
      // a line between query and talker drops the reply
      u_ctl.send_line(`ARCP_C_CTLQ, 8, 1'b1);
      cmd(`ARCP_C_LOCAL, 5);
      u_ctl.read_reply(1'b0, 30);
      chk_reply(160'h0, 0);
      // aborted partial line must not spoil the next one
      u_ctl.send_line(`ARCP_C_REMOTE >> 24, 3, 1'b0);
      @(posedge mclk);
      dev_clear <= 1'b1;
      @(posedge mclk);
      dev_clear <= 1'b0;
      @(negedge mclk);
      chk_val({6'h00, ctrl_point}, {6'h00, `ARCP_CP_LOCAL});
      cmd(`ARCP_C_REMOTE, 6);
      chk_val({6'h00, ctrl_point}, {6'h00, `ARCP_CP_GPIB});
      @(posedge mclk);
      fault_temp <= 1'b1;
      temp_num <= 4'h3;
      tick(2);
      chk_val({7'h00, srq}, 8'h01);
      @(posedge mclk);
      fault_psu <= 1'b1;
      psu_num <= 4'h5;
      qry(`ARCP_C_STSQ, 7, 1'b0);
      chk_reply({`ARCP_S_TEMP, 8'h33, 8'h0A}, 14);
      spoll_req <= 1'b1;
      @(posedge mclk);
      spoll_req <= 1'b0;
      @(negedge mclk);
      chk_val(stb_data, 8'h42);
      chk_val({7'h00, stb_valid}, 8'h01);
      chk_val({7'h00, srq}, 8'h00);
      @(posedge mclk);
      fault_temp <= 1'b0;
      fault_psu <= 1'b0;
      tick(2);
      chk_val({7'h00, fault_active}, 8'h01);
      cmd(`ARCP_C_RST, 4);
      qry(`ARCP_C_STSQ, 7, 1'b1);
      chk_reply({`ARCP_S_OK, 8'h0A}, 10);
      qry(`ARCP_C_IDNQ, 5, 1'b0);
      chk_reply({ID, 8'h0A}, 17);
      close_out;
   end
endmodule
`default_nettype wire
